// File: irc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "irc_defs.vh"
// Summary of operation
// - First character of an instruction is op code and must carry word mark.
// - Invalid op code raises instruction check and halts the processor.
// - Input-output op code routes the character after the op code to the unit-select register.
// - Grouping picks first-address load: all four, first and third, or third only.
// - Zones over ten-thousands, thousands or units digit raise address check.
// - Zones over hundreds and tens digits load index tag latches.
// - Word length not permitted for op code raises instruction check.
// - Read-out normally starts from final execute cycle of previous operation.
// - Final execute cycle sets cycle and ring control at late clock point.
// - Indexing suspends read-out, modifies one address register, then resumes.
// - Later characters go to the register chosen by the op code decode.
// - Decode yields shared grouping lines for read-out and execution.
module irc_top (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Sequencing from execution control
  input wire last_exec_cycle,
  input wire late_cycle_clock_point,
  // Character storage
  input wire char_valid,
  input wire [7:0] char_in,
  output reg char_req_ff,
  // Indexing unit
  input wire index_done,
  output reg index_req_ff,
  output reg [3:0] index_tag_ff,
  // Outputs to execution
  output reg [5:0] op_reg_ff,
  output reg [`IRC_GRP_W-1:0] op_group_ff,
  output reg [5:0] io_select_ff,
  output reg [19:0] first_operand_addr_reg_ff,
  output reg [19:0] second_addr_reg_ff,
  output reg [19:0] third_addr_reg_ff,
  output reg [19:0] fourth_addr_reg_ff,
  output reg [5:0] modifier_ff,
  output reg [`IRC_RING_W-1:0] ring_ff,
  output reg i_cycle_ff,
  output reg readout_done_ff,
  output reg instr_check_ff,
  output reg addr_check_ff
);

// ==========================================
// Decode
function [`IRC_GRP_W-1:0] op_decode;
  input [5:0] op;
  begin
    case (op)
      `IRC_OP_IO_A, `IRC_OP_IO_B: op_decode = 5'h03;
      `IRC_OP_ALL_A, `IRC_OP_ALL_B: op_decode = 5'h05;
      `IRC_OP_AC: op_decode = 5'h09;
      `IRC_OP_C: op_decode = 5'h11;
      default: op_decode = 5'h00;
    endcase
  end
endfunction

function len_ok;
  input [`IRC_GRP_W-1:0] grp;
  input [3:0] len;
  reg [11:0] m;
  begin
    m = grp[`IRC_GRP_IO] ? `IRC_LEN_IO : grp[`IRC_GRP_C] ? `IRC_LEN_C :
        grp[`IRC_GRP_AC] ? `IRC_LEN_AC : `IRC_LEN_ALL;
    // Words longer than the ring can hold are never a legal length
    len_ok = (len < 4'hc) ? m[len] : 1'b0;
  end
endfunction

// ==========================================
// Sequencer
localparam S_IDLE = 4'h1;
localparam S_READ = 4'h2;
localparam S_INDEX = 4'h4;
localparam S_HALT = 4'h8;

reg [3:0] state_ff;
reg [3:0] count_ff;
reg [3:0] digit_ff;
reg [1:0] addr_sel_ff;
reg [19:0] addr_acc_ff;
reg zone_hold_ff;

wire [5:0] ch6 = char_in[5:0];
wire has_wm = char_in[`IRC_CH_WM];
wire has_zone = char_in[`IRC_CH_B] | char_in[`IRC_CH_A];
wire [`IRC_GRP_W-1:0] grp_now = op_decode(ch6);
wire [19:0] acc_next = {addr_acc_ff[15:0], char_in[`IRC_CH_NU_HI:0]};
wire take = char_valid & char_req_ff;

always @(posedge mclk or posedge reset) begin
  if (reset) begin
    state_ff <= S_IDLE;
    char_req_ff <= 1'b0;
    index_req_ff <= 1'b0;
    index_tag_ff <= 4'h0;
    op_reg_ff <= 6'h00;
    op_group_ff <= 5'h00;
    io_select_ff <= 6'h00;
    first_operand_addr_reg_ff <= 20'h00000;
    second_addr_reg_ff <= 20'h00000;
    third_addr_reg_ff <= 20'h00000;
    fourth_addr_reg_ff <= 20'h00000;
    modifier_ff <= 6'h00;
    ring_ff <= 12'h000;
    i_cycle_ff <= 1'b0;
    readout_done_ff <= 1'b0;
    instr_check_ff <= 1'b0;
    addr_check_ff <= 1'b0;
    count_ff <= 4'h0;
    digit_ff <= 4'h0;
    addr_sel_ff <= 2'h0;
    addr_acc_ff <= 20'h00000;
    zone_hold_ff <= 1'b0;
  end else begin
    readout_done_ff <= 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (last_exec_cycle & late_cycle_clock_point) begin
          state_ff <= S_READ;
          i_cycle_ff <= 1'b1;
          ring_ff <= 12'h001;
          char_req_ff <= 1'b1;
          count_ff <= 4'h0;
          digit_ff <= 4'h0;
          addr_sel_ff <= 2'h0;
          index_tag_ff <= 4'h0;
        end
      end
      S_READ: begin
        if (take) begin
          if (count_ff == 4'h0) begin
            op_reg_ff <= ch6;
            op_group_ff <= grp_now;
            if (~has_wm | ~grp_now[0]) begin
              instr_check_ff <= 1'b1;
              state_ff <= S_HALT;
              char_req_ff <= 1'b0;
            end
            count_ff <= 4'h1;
            ring_ff <= {ring_ff[10:0], 1'b0};
          end else if (has_wm) begin
            // Word mark on a later character starts the next instruction: end here
            char_req_ff <= 1'b0;
            ring_ff <= 12'h000;
            i_cycle_ff <= 1'b0;
            if (~len_ok(op_group_ff, count_ff)) begin
              instr_check_ff <= 1'b1;
              state_ff <= S_HALT;
            end else begin
              readout_done_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
          end else begin
            count_ff <= count_ff + 4'h1;
            ring_ff <= {ring_ff[10:0], 1'b0};
            if (op_group_ff[`IRC_GRP_IO] & (count_ff == 4'h1)) begin
              io_select_ff <= ch6;
            end else begin
              addr_acc_ff <= acc_next;
              if (digit_ff == 4'h0) begin
                zone_hold_ff <= has_zone;
                // Past the first address this may be the modifier; its zones count only if a digit follows
                if (addr_sel_ff != 2'h0)
                  modifier_ff <= ch6;
              end
              if ((has_zone & ((digit_ff == 4'h1) | (digit_ff == 4'h4))) |
                  (has_zone & (digit_ff == 4'h0) & (addr_sel_ff == 2'h0)) |
                  (zone_hold_ff & (digit_ff == 4'h1))) begin
                addr_check_ff <= 1'b1;
                state_ff <= S_HALT;
                char_req_ff <= 1'b0;
              end
              if (digit_ff == 4'h2)
                index_tag_ff[3:2] <= char_in[5:4];
              if (digit_ff == 4'h3)
                index_tag_ff[1:0] <= char_in[5:4];
              if (digit_ff == 4'h4) begin
                digit_ff <= 4'h0;
                addr_sel_ff <= addr_sel_ff + 2'h1;
                if (addr_sel_ff == 2'h0) begin
                  if (op_group_ff[`IRC_GRP_ALL] | op_group_ff[`IRC_GRP_IO]) begin
                    first_operand_addr_reg_ff <= acc_next;
                    second_addr_reg_ff <= acc_next;
                    third_addr_reg_ff <= acc_next;
                    fourth_addr_reg_ff <= acc_next;
                  end else if (op_group_ff[`IRC_GRP_AC]) begin
                    first_operand_addr_reg_ff <= acc_next;
                    third_addr_reg_ff <= acc_next;
                  end else begin
                    third_addr_reg_ff <= acc_next;
                  end
                end else begin
                  second_addr_reg_ff <= acc_next;
                end
                // A zoned units digit is an address check, never an index request
                if ((index_tag_ff != 4'h0) & ~has_zone) begin
                  char_req_ff <= 1'b0;
                  index_req_ff <= 1'b1;
                  state_ff <= S_INDEX;
                end
              end else begin
                digit_ff <= digit_ff + 4'h1;
              end
            end
          end
        end
      end
      S_INDEX: begin
        // Indexing unit owns the address register until done
        if (index_done) begin
          index_req_ff <= 1'b0;
          index_tag_ff <= 4'h0;
          char_req_ff <= 1'b1;
          state_ff <= S_READ;
        end
      end
      S_HALT: begin
        // Checks hold the processor until reset
        char_req_ff <= 1'b0;
        i_cycle_ff <= 1'b0;
        ring_ff <= 12'h000;
      end
      default: state_ff <= S_IDLE;
    endcase
  end
end

endmodule // irc_top
`default_nettype wire

// File: irc_defs.vh
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH
// Character layout: {word_mark, check, B, A, 8, 4, 2, 1}
`define IRC_CH_WM 7
`define IRC_CH_B 5
`define IRC_CH_A 4
`define IRC_CH_NU_HI 3
// Ring width (op position plus up to eleven later characters)
`define IRC_RING_W 12
// Op-code classes: bit0 valid, bit1 input-output, bit2 all-four, bit3 a+c, bit4 c-only
`define IRC_GRP_W 5
`define IRC_GRP_IO 1
`define IRC_GRP_ALL 2
`define IRC_GRP_AC 3
`define IRC_GRP_C 4
// Legal length masks, bit n set means an n-character word is allowed
`define IRC_LEN_IO 12'h441
`define IRC_LEN_ALL 12'h8b3
`define IRC_LEN_AC 12'h8b3
`define IRC_LEN_C 12'h063
// Operation codes used by the decoder (six-bit BA8421 form)
`define IRC_OP_IO_A 6'h21
`define IRC_OP_IO_B 6'h22
`define IRC_OP_ALL_A 6'h31
`define IRC_OP_ALL_B 6'h32
`define IRC_OP_AC 6'h14
`define IRC_OP_C 6'h11
`endif

// File: irc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Read-out checker
module irc_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Inputs
  input wire logic last_exec_cycle,
  input wire logic late_cycle_clock_point,
  input wire logic char_valid,
  input wire logic [7:0] char_in,
  input wire logic index_done,
  // Outputs
  input wire logic char_req_ff,
  input wire logic index_req_ff,
  input wire logic [5:0] op_reg_ff,
  input wire logic [11:0] ring_ff,
  input wire logic i_cycle_ff,
  input wire logic readout_done_ff,
  input wire logic instr_check_ff,
  input wire logic addr_check_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic take = char_valid && char_req_ff;
  wire logic halt = instr_check_ff || addr_check_ff;
  start_ring_a: assert property (last_exec_cycle && late_cycle_clock_point && !i_cycle_ff && !halt
    |=> ring_ff == 12'h001 && i_cycle_ff && char_req_ff) else $error("start missed");
  op_load_a: assert property (take && ring_ff[0] && char_in[7]
    |=> op_reg_ff == $past(char_in[5:0])) else $error("op not loaded");
  ring_step_a: assert property (take && !char_in[7] && !ring_ff[0] && !ring_ff[11]
    |=> ring_ff == ($past(ring_ff) << 1) || halt) else $error("ring did not step");
  word_end_a: assert property (take && char_in[7] && !ring_ff[0]
    |-> ##[1:2] ring_ff == 12'h000 && !i_cycle_ff) else $error("ring not cleared");
  end_verdict_a: assert property (take && char_in[7] && !ring_ff[0]
    |-> ##[1:2] readout_done_ff || instr_check_ff) else $error("no end verdict");
  check_halt_a: assert property (halt |=> !char_req_ff && $stable({instr_check_ff, addr_check_ff}))
    else $error("check did not halt");
  index_wait_a: assert property (index_req_ff && !index_done
    |=> index_req_ff && !char_req_ff) else $error("read-out not suspended");
  index_resume_a: assert property (index_req_ff && index_done
    |=> !index_req_ff ##[0:1] char_req_ff) else $error("read-out not resumed");
  done_pulse_a: assert property (readout_done_ff |=> !readout_done_ff)
    else $error("done held");
endmodule // irc_assertions
bind irc_top irc_assertions i_chk (.mclk, .reset, .last_exec_cycle, .late_cycle_clock_point, .char_valid,
  .char_in, .index_done, .char_req_ff, .index_req_ff, .op_reg_ff, .ring_ff, .i_cycle_ff, .readout_done_ff,
  .instr_check_ff, .addr_check_ff);
`default_nettype wire

// File: irc_store_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Storage and indexing unit
module irc_store_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Block side
  input wire logic char_req_ff,
  input wire logic index_req_ff,
  output logic char_valid,
  output logic [7:0] char_in,
  output logic index_done,
  // Pace
  input wire logic slow
);
  logic [7:0] mem [0:7];
  logic [2:0] ptr_ff;
  logic tgl_ff;
  logic [1:0] wait_ff;
  assign char_valid = !slow || tgl_ff;
  // Off cycles show the inverse so a stale sample is caught
  assign char_in = char_valid ? mem[ptr_ff] : ~mem[ptr_ff];
  assign index_done = &wait_ff;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ptr_ff <= 3'h0;
      tgl_ff <= 1'b0;
      wait_ff <= 2'h0;
    end else begin
      tgl_ff <= !tgl_ff;
      if (char_valid && char_req_ff) begin
        ptr_ff <= ptr_ff + 3'h1;
      end
      wait_ff <= (index_req_ff && !index_done) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule // irc_store_model
`default_nettype wire

// File: irc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module irc_top_bench;
  logic mclk, reset, last_exec_cycle, late_cycle_clock_point, slow, dn;
  logic char_valid, index_done, char_req_ff, index_req_ff, readout_done_ff, instr_check_ff, addr_check_ff;
  logic [7:0] char_in;
  logic [3:0] index_tag_ff;
  logic [3:0] tag_seen;
  logic [4:0] op_group_ff;
  logic [5:0] modifier_ff;
  logic [5:0] io_select_ff;
  logic [19:0] first_operand_addr_reg_ff, second_addr_reg_ff, third_addr_reg_ff, fourth_addr_reg_ff;
  integer err_total = 0, samples_checked = 0, tn = 0;
  irc_top i_dut (.mclk, .reset, .last_exec_cycle, .late_cycle_clock_point, .char_valid, .char_in,
    .char_req_ff, .index_done, .index_req_ff, .index_tag_ff, .op_reg_ff(), .op_group_ff, .io_select_ff,
    .first_operand_addr_reg_ff, .second_addr_reg_ff, .third_addr_reg_ff, .fourth_addr_reg_ff,
    .modifier_ff, .ring_ff(), .i_cycle_ff(), .readout_done_ff, .instr_check_ff, .addr_check_ff);
  irc_store_model i_mem (.mclk, .reset, .char_req_ff, .index_req_ff, .char_valid, .char_in, .index_done, .slow);
  // Tags are cleared once indexing ends, so keep what stood during the request
  always @(posedge mclk or posedge reset) begin
    if (reset)
      tag_seen <= 4'h0;
    else if (index_req_ff === 1'b1)
      tag_seen <= index_tag_ff;
  end
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // ==========
  // Checking
  task chk(input string n, input logic [19:0] s, e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task fin(input logic [2:0] e);
    chk("flags", {instr_check_ff, addr_check_ff, dn}, e);
    tn = tn + 1;
    $display("test %0d ended", tn);
  endtask
  task adr(input logic [19:0] a, b, c, d);
    chk("first", first_operand_addr_reg_ff, a);
    chk("second", second_addr_reg_ff, b);
    chk("third", third_addr_reg_ff, c);
    chk("fourth", fourth_addr_reg_ff, d);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // One instruction: load storage, reset, start, wait for an end
  task go(input logic [63:0] w);
    integer i;
    for (i = 0; i < 8; i = i + 1)
      i_mem.mem[i] = w[63 - 8 * i -: 8];
    reset = 1;
    dn = 0;
    repeat (2) @(posedge mclk);
    #2 reset = 0;
    @(posedge mclk);
    #2 last_exec_cycle = 1;
    late_cycle_clock_point = 1;
    @(posedge mclk);
    #2 last_exec_cycle = 0;
    late_cycle_clock_point = 0;
    for (i = 0; i < 99 && !dn && (instr_check_ff | addr_check_ff) !== 1'b1; i = i + 1) begin
      @(posedge mclk);
      #2 dn = (readout_done_ff === 1'b1);
    end
    // A word that never ends counts against the run
    chk("ended", {19'h0, dn | instr_check_ff | addr_check_ff}, 20'h1);
  endtask
  initial begin
    reset = 1;
    last_exec_cycle = 0;
    late_cycle_clock_point = 0;
    slow = 0;
    go(64'h91_01_02_03_04_05_80_80);
    adr(20'h0, 20'h0, 20'h12345, 20'h0);
    chk("group", op_group_ff, 20'h11);
    fin(3'b001);
    slow = 1;
    go(64'hb1_09_08_07_06_05_23_80);
    adr(20'h98765, 20'h98765, 20'h98765, 20'h98765);
    chk("group", op_group_ff, 20'h05);
    chk("modifier", modifier_ff, 20'h23);
    fin(3'b001);
    go(64'h94_01_02_03_04_05_80_80);
    adr(20'h12345, 20'h0, 20'h12345, 20'h0);
    chk("group", op_group_ff, 20'h09);
    fin(3'b100);
    slow = 0;
    go(64'ha1_2a_01_02_03_04_05_80);
    chk("select", io_select_ff, 20'h2a);
    chk("group", op_group_ff, 20'h03);
    fin(3'b100);
    go(64'hbf_80_80_80_80_80_80_80);
    fin(3'b100);
    go(64'h11_01_02_03_04_05_80_80);
    fin(3'b100);
    go(64'hb1_01_02_80_80_80_80_80);
    fin(3'b100);
    go(64'h91_01_02_03_04_25_80_80);
    fin(3'b010);
    go(64'h91_11_02_03_04_05_80_80);
    fin(3'b010);
    go(64'h91_01_02_23_14_05_80_80);
    chk("tag", tag_seen, 20'h9);
    adr(20'h0, 20'h0, 20'h12345, 20'h0);
    fin(3'b001);
    summarize;
  end
  // Tests take well under 20 us
  initial begin
    #200000;
    err_total = err_total + 1;
    summarize;
  end
endmodule // irc_top_bench
`default_nettype wire
